//--- tdp_cfg.svh
// register offsets, control field positions, reset values and prescale counts
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH
`define TDP_OFF_LCTRL 8'h00
`define TDP_OFF_UCTRL 8'h04
`define TDP_OFF_LCNT 8'h08
`define TDP_OFF_UCNT 8'h0C
`define TDP_OFF_LPER 8'h10
`define TDP_OFF_UPER 8'h14
`define TDP_OFF_STAT 8'h18
`define TDP_OFF_MASK 8'h1C
`define TDP_OFF_PRIO 8'h20
`define TDP_BIT_RUN 15
`define TDP_BIT_HALT 13
`define TDP_BIT_GATE 6
`define TDP_BIT_DIV_HI 5
`define TDP_BIT_DIV_LO 4
`define TDP_BIT_JOIN 3
`define TDP_BIT_SRC 1
`define TDP_LCTRL_MASK 16'hA07A
`define TDP_UCTRL_MASK 16'hA072
`define TDP_CTRL_RST 16'h0000
`define TDP_CNT_RST 16'h0000
`define TDP_PER_RST 16'hFFFF
`define TDP_DIV1_MAX 8'h00
`define TDP_DIV8_MAX 8'h07
`define TDP_DIV64_MAX 8'h3F
`define TDP_DIV256_MAX 8'hFF
`define TDP_RESP_OKAY 2'h0
`define TDP_RESP_SLVERR 2'h2
`endif

//--- tdp_pkg.sv
// types shared by the timer pair
package tdp_pkg;
   typedef struct packed {
      logic run;
      logic halt;
      logic gate;
      logic [1:0] div;
      logic src;
   } tdp_ctrl_t;
endpackage

//--- tdp_timer_pair.sv
// cascadable pair of 16-bit timers with an AXI4-Lite register slave
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tdp_cfg.svh"

module tdp_timer_pair #(
   parameter int ADDR_W = 8,
   parameter int PAIR_INDEX = 0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lower_ext_clock_pin,
   input wire logic upper_ext_clock_pin,
   input wire logic idle_mode,
   input wire logic capture_timebase_select,
   output logic irq,
   output logic [2:0] irq_priority,
   output logic adc1_trigger,
   output logic adc2_trigger,
   output logic dma_trigger,
   output logic [15:0] timebase_lower,
   output logic [15:0] timebase_upper,
   output logic [15:0] capture_word
);

   localparam logic FIRST_PAIR = (PAIR_INDEX == 0);
   localparam logic SECOND_PAIR = (PAIR_INDEX == 1);

   function automatic logic [7:0] div_max(input logic [1:0] code);
      case (code)
         2'b00: div_max = `TDP_DIV1_MAX;
         2'b01: div_max = `TDP_DIV8_MAX;
         2'b10: div_max = `TDP_DIV64_MAX;
         default: div_max = `TDP_DIV256_MAX;
      endcase
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) merge16[7:0] = d[7:0];
      if (strb[1]) merge16[15:8] = d[15:8];
   endfunction

   function automatic tdp_pkg::tdp_ctrl_t to_ctrl(input logic [15:0] r);
      to_ctrl.run = r[`TDP_BIT_RUN];
      to_ctrl.halt = r[`TDP_BIT_HALT];
      to_ctrl.gate = r[`TDP_BIT_GATE];
      to_ctrl.div = r[`TDP_BIT_DIV_HI:`TDP_BIT_DIV_LO];
      to_ctrl.src = r[`TDP_BIT_SRC];
   endfunction

   function automatic logic [7:0] reg_slot(input logic [ADDR_W-1:0] a);
      reg_slot = ((a >> 8) != '0) ? 8'hFF : (8'(a) & 8'hFC);
   endfunction

   logic [15:0] ctrl_q [2];
   logic [15:0] count_q [2];
   logic [15:0] period_q [2];
   logic [7:0] pre_q [2];
   logic [2:0] prio_q [2];
   logic [1:0] status_q, mask_q, pin_s1_q, pin_s2_q, pin_s3_q, ext_rise, ext_fall;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [ADDR_W-1:0] rd_addr_q;
   tdp_pkg::tdp_ctrl_t cfg [2];
   logic [1:0] run_en, raw_tick, pre_tick, match16, ev_match, gate_fall_ev, ev;
   logic [1:0] pin_sel [2];
   logic [1:0] wr_ctrl, wr_cnt, wr_per;
   logic join_mode, match32, wr_fire, wr_mapped, wr_stat, wr_mask, wr_prio, rd_mapped;
   logic [31:0] rd_data;

   // pins come from outside the clock domain; no asynchronous count path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
      end else begin
         pin_s1_q <= {upper_ext_clock_pin, lower_ext_clock_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign ext_rise = pin_s2_q & ~pin_s3_q;
   assign ext_fall = ~pin_s2_q & pin_s3_q;

   // effective configuration per timer
   always_comb begin
      join_mode = ctrl_q[0][`TDP_BIT_JOIN];
      cfg[0] = to_ctrl(ctrl_q[0]);
      cfg[1] = join_mode ? cfg[0] : to_ctrl(ctrl_q[1]);
      pin_sel[0] = 2'b01;
      pin_sel[1] = join_mode ? 2'b01 : 2'b10;
      for (int i = 0; i < 2; i++) begin
         // upper halt bit still stops a joined timer in idle mode, so software must clear it
         run_en[i] = cfg[i].run && !(join_mode && i == 1) && !(idle_mode && (cfg[i].halt ||
                     (join_mode && ctrl_q[1][`TDP_BIT_HALT])));
         if (cfg[i].src)
            raw_tick[i] = |(ext_rise & pin_sel[i]);
         else if (cfg[i].gate)
            raw_tick[i] = |(pin_s2_q & pin_sel[i]);
         else
            raw_tick[i] = 1'b1;
         gate_fall_ev[i] = run_en[i] && cfg[i].gate && !cfg[i].src && |(ext_fall & pin_sel[i]);
         match16[i] = count_q[i] == period_q[i];
         pre_tick[i] = run_en[i] && raw_tick[i] && (pre_q[i] == div_max(cfg[i].div));
      end
      gate_fall_ev[1] = join_mode ? gate_fall_ev[0] : gate_fall_ev[1];
      match32 = {count_q[1], count_q[0]} == {period_q[1], period_q[0]};
      ev_match[0] = !join_mode && pre_tick[0] && match16[0];
      ev_match[1] = join_mode ? (pre_tick[0] && match32) : (pre_tick[1] && match16[1]);
      ev[0] = ev_match[0] || (!join_mode && gate_fall_ev[0]);
      ev[1] = ev_match[1] || gate_fall_ev[1];
   end

   // prescalers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q[0] <= 8'h00;
         pre_q[1] <= 8'h00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run_en[i])
               pre_q[i] <= 8'h00;
            else if (raw_tick[i])
               pre_q[i] <= (pre_q[i] == div_max(cfg[i].div)) ? 8'h00 : pre_q[i] + 8'h01;
         end
      end
   end

   // counters; a software write wins over a tick in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q[0] <= `TDP_CNT_RST;
         count_q[1] <= `TDP_CNT_RST;
      end else begin
         if (join_mode && pre_tick[0])
            {count_q[1], count_q[0]} <= match32 ? 32'h0000_0000 :
                                        {count_q[1], count_q[0]} + 32'h0000_0001;
         for (int i = 0; i < 2; i++) begin
            if (!join_mode && pre_tick[i])
               count_q[i] <= match16[i] ? 16'h0000 : count_q[i] + 16'h0001;
            if (wr_cnt[i])
               count_q[i] <= merge16(count_q[i], wdata_q, wstrb_q);
         end
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q[0] <= `TDP_CTRL_RST;
         ctrl_q[1] <= `TDP_CTRL_RST;
         period_q[0] <= `TDP_PER_RST;
         period_q[1] <= `TDP_PER_RST;
         mask_q <= 2'h0;
         prio_q[0] <= 3'h0;
         prio_q[1] <= 3'h0;
      end else begin
         if (wr_ctrl[0])
            ctrl_q[0] <= merge16(ctrl_q[0], wdata_q, wstrb_q) & `TDP_LCTRL_MASK;
         if (wr_ctrl[1])
            ctrl_q[1] <= merge16(ctrl_q[1], wdata_q, wstrb_q) & `TDP_UCTRL_MASK;
         for (int i = 0; i < 2; i++) begin
            if (wr_per[i])
               period_q[i] <= merge16(period_q[i], wdata_q, wstrb_q);
         end
         if (wr_mask && wstrb_q[0])
            mask_q <= wdata_q[1:0];
         if (wr_prio && wstrb_q[0]) begin
            prio_q[0] <= wdata_q[2:0];
            prio_q[1] <= wdata_q[6:4];
         end
      end
   end

   // sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 2'h0;
      end else begin
         status_q <= (status_q & ~((wr_stat && wstrb_q[0]) ? wdata_q[1:0] : 2'h0)) | ev;
      end
   end

   // interrupt and triggers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
         irq_priority <= 3'h0;
         adc1_trigger <= 1'b0;
         adc2_trigger <= 1'b0;
         dma_trigger <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
         irq_priority <= (status_q[1] && mask_q[1]) ? prio_q[1] : prio_q[0];
         adc1_trigger <= FIRST_PAIR && ev_match[1];
         adc2_trigger <= SECOND_PAIR && ev_match[1];
         dma_trigger <= FIRST_PAIR && (|ev_match);
      end
   end

   // time base for capture and compare, one cycle behind the counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timebase_lower <= 16'h0000;
         timebase_upper <= 16'h0000;
         capture_word <= 16'h0000;
      end else begin
         timebase_lower <= FIRST_PAIR ? count_q[0] : 16'h0000;
         timebase_upper <= FIRST_PAIR ? count_q[1] : 16'h0000;
         capture_word <= capture_timebase_select ? count_q[0] : count_q[1];
      end
   end

   // write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TDP_RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `TDP_RESP_OKAY : `TDP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_comb begin
      wr_ctrl = 2'h0;
      wr_cnt = 2'h0;
      wr_per = 2'h0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      wr_prio = 1'b0;
      wr_mapped = 1'b1;
      if (wr_fire) begin
         case (reg_slot(awaddr_q))
            `TDP_OFF_LCTRL: wr_ctrl[0] = 1'b1;
            `TDP_OFF_UCTRL: wr_ctrl[1] = 1'b1;
            `TDP_OFF_LCNT: wr_cnt[0] = 1'b1;
            `TDP_OFF_UCNT: wr_cnt[1] = 1'b1;
            `TDP_OFF_LPER: wr_per[0] = 1'b1;
            `TDP_OFF_UPER: wr_per[1] = 1'b1;
            `TDP_OFF_STAT: wr_stat = 1'b1;
            `TDP_OFF_MASK: wr_mask = 1'b1;
            `TDP_OFF_PRIO: wr_prio = 1'b1;
            default: wr_mapped = 1'b0;
         endcase
      end
   end

   // read decode; reserved bits and upper halfword read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (reg_slot(s_axi_araddr))
         `TDP_OFF_LCTRL: rd_data[15:0] = ctrl_q[0];
         `TDP_OFF_UCTRL: rd_data[15:0] = ctrl_q[1];
         `TDP_OFF_LCNT: rd_data[15:0] = count_q[0];
         `TDP_OFF_UCNT: rd_data[15:0] = count_q[1];
         `TDP_OFF_LPER: rd_data[15:0] = period_q[0];
         `TDP_OFF_UPER: rd_data[15:0] = period_q[1];
         `TDP_OFF_STAT: rd_data[1:0] = status_q;
         `TDP_OFF_MASK: rd_data[1:0] = mask_q;
         `TDP_OFF_PRIO: rd_data[6:0] = {prio_q[1], 1'b0, prio_q[0]};
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TDP_RESP_OKAY;
         rd_addr_q <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_mapped ? `TDP_RESP_OKAY : `TDP_RESP_SLVERR;
            rd_addr_q <= s_axi_araddr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_div8_tick;
      pre_tick[0] && cfg[0].div == 2'b01 && !cfg[0].src && !cfg[0].gate && !wr_ctrl[0];
   endsequence
   sequence s_div8_gap;
      (!pre_tick[0]) [*7];
   endsequence
   AST_DIV8_GAP: assert property (s_div8_tick |=> s_div8_gap)
      else $error("prescale by 8 ticked early");
   AST_WRAP16: assert property (!join_mode && pre_tick[0] && match16[0] && !wr_cnt[0]
      |=> count_q[0] == 16'h0000 && status_q[0])
      else $error("16-bit match did not clear count and set flag");
   AST_JOIN_CARRY: assert property (join_mode && pre_tick[0] && !match32 &&
      count_q[0] == 16'hFFFF && wr_cnt == 2'h0
      |=> count_q[0] == 16'h0000 && count_q[1] == $past(count_q[1]) + 16'h0001)
      else $error("lower rollover did not carry into upper word");
   AST_JOIN_FLAG: assert property (join_mode && pre_tick[0] && match32
      |=> status_q[1] && {count_q[1], count_q[0]} == $past(wr_cnt != 2'h0 ?
      {count_q[1], count_q[0]} : 32'h0000_0000) || $past(wr_cnt) != 2'h0)
      else $error("32-bit match missed upper flag");
   AST_JOIN_NO_LOWER: assert property ($rose(status_q[0]) |-> !$past(join_mode))
      else $error("lower flag set in joined mode");
   AST_UPPER_IDLE_JOIN: assert property (join_mode |-> !pre_tick[1])
      else $error("upper prescaler ran in joined mode");
   AST_STOPPED: assert property (!cfg[0].run && !wr_cnt[0] |=> $stable(count_q[0]))
      else $error("stopped timer counted");
   AST_IDLE_HALT: assert property (idle_mode && cfg[0].halt |-> !pre_tick[0] && !run_en[0])
      else $error("timer ran in idle with halt set");
   AST_EXT_EDGE: assert property (cfg[0].src && !ext_rise[0] |-> !pre_tick[0])
      else $error("external mode ticked without a synchronised edge");
   AST_RESV_ZERO: assert property ($rose(s_axi_rvalid) &&
      (8'(rd_addr_q) & 8'hFC) == `TDP_OFF_LCTRL |-> s_axi_rdata[12:7] == 6'h00 &&
      s_axi_rdata[31:16] == 16'h0000)
      else $error("reserved control bits read nonzero");
   AST_IRQ_LEVEL: assert property (##1 irq == $past(|(status_q & mask_q)))
      else $error("interrupt output disagrees with flags");
   AST_ADC_SRC: assert property (adc1_trigger |-> FIRST_PAIR && $past(ev_match[1]))
      else $error("adc1 trigger from wrong pair or without match");
   AST_CAPSEL: assert property (##1 capture_word ==
      $past(capture_timebase_select ? count_q[0] : count_q[1]))
      else $error("capture word from wrong timer");
endmodule // tdp_timer_pair

//--- tdp_pin_model.sv
// model of the external clock and gate pins that feed the timer pair
`timescale 1ns/1ps
module tdp_pin_model (
   input wire logic aclk,
   output logic lower_ext_clock_pin,
   output logic upper_ext_clock_pin
);
   logic [1:0] pin_q = 2'h0;
   assign lower_ext_clock_pin = pin_q[0];
   assign upper_ext_clock_pin = pin_q[1];
   // n rising edges, each level held half cycles; pins rest low between bursts
   task automatic pulses(input int sel, input int n, input int half);
      repeat (n) begin
         @(posedge aclk);
         pin_q[sel] <= 1'b1;
         repeat (half) @(posedge aclk);
         pin_q[sel] <= 1'b0;
         repeat (half - 1) @(posedge aclk);
      end
   endtask
   // level window for gated accumulation
   task automatic hold(input int sel, input int n);
      @(posedge aclk);
      pin_q[sel] <= 1'b1;
      repeat (n) @(posedge aclk);
      pin_q[sel] <= 1'b0;
   endtask
endmodule // tdp_pin_model

//--- tdp_timer_pair_tb.sv
// self-checking bench for the timer pair over its register bus
`timescale 1ns/1ps
`include "tdp_cfg.svh"
module tdp_timer_pair_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdat, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, adc1, adc2, dma;
   logic [1:0] bresp, rresp, rsp;
   logic [2:0] prio;
   logic idle = 1'b0, cap_sel = 1'b0;
   logic [15:0] tb_lo, tb_hi, cap;
   logic lpin, upin;
   int fails = 0, n_checks = 0, cyc = 0, adc2_seen = 0, n;
   int divs[4] = '{1, 8, 64, 256};
   always #20 aclk = ~aclk;
   tdp_pin_model pm (.aclk(aclk), .lower_ext_clock_pin(lpin), .upper_ext_clock_pin(upin));
   tdp_timer_pair #(.ADDR_W(8), .PAIR_INDEX(0)) uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lower_ext_clock_pin(lpin), .upper_ext_clock_pin(upin),
      .idle_mode(idle), .capture_timebase_select(cap_sel), .irq(irq),
      .irq_priority(prio), .adc1_trigger(adc1), .adc2_trigger(adc2),
      .dma_trigger(dma), .timebase_lower(tb_lo), .timebase_upper(tb_hi),
      .capture_word(cap));
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // a hang anywhere ends here; the whole run needs well under this
   always @(posedge aclk) begin
      cyc++;
      if (adc2 === 1'b1) adc2_seen++;
      if (cyc == 30000) begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rdat = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(what, e, rdat);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("lower ctrl reset", `TDP_OFF_LCTRL, 32'h0);
      rchk("upper ctrl reset", `TDP_OFF_UCTRL, 32'h0);
      rchk("lower period reset", `TDP_OFF_LPER, 32'hFFFF);
      wr(`TDP_OFF_LCTRL, 32'hFFFF);
      rchk("lower ctrl unused bits", `TDP_OFF_LCTRL, 32'hA07A);
      wr(`TDP_OFF_UCTRL, 32'hFFFF);
      rchk("upper ctrl unused bits", `TDP_OFF_UCTRL, 32'hA072);
      wr(`TDP_OFF_LCTRL, 32'h0);
      wr(`TDP_OFF_UCTRL, 32'h0);
      rchk("unmapped read data", 8'h24, 32'h0);
      chk("unmapped read resp", `TDP_RESP_SLVERR, rsp);
      wr(8'h24, 32'h1);
      chk("unmapped write resp", `TDP_RESP_SLVERR, rsp);
      $display("test registers done");
      // match every (period+1)*divide cycles, count restarts at zero
      wr(`TDP_OFF_LPER, 32'h3);
      for (int c = 0; c < 4; c++) begin
         wr(`TDP_OFF_LCTRL, 32'h8000 | (c << 4));
         do @(posedge aclk); while (dma !== 1'b1);
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (dma !== 1'b1);
         chk("match interval", 4 * divs[c], n);
         wr(`TDP_OFF_LCTRL, 32'h0);
         wr(`TDP_OFF_LCNT, 32'h0);
      end
      rchk("lower flag set", `TDP_OFF_STAT, 32'h1);
      wr(`TDP_OFF_STAT, 32'h3);
      $display("test prescale done");
      // joined: carry from lower word, 32-bit match, upper flag only
      wr(`TDP_OFF_LCTRL, 32'h0008);
      wr(`TDP_OFF_LCNT, 32'hFFF0);
      wr(`TDP_OFF_UCNT, 32'h0);
      wr(`TDP_OFF_LPER, 32'h2);
      wr(`TDP_OFF_UPER, 32'h1);
      wr(`TDP_OFF_MASK, 32'h2);
      wr(`TDP_OFF_PRIO, 32'h51);
      wr(`TDP_OFF_LCTRL, 32'h8008);
      do @(posedge aclk); while (adc1 !== 1'b1);
      repeat (2) @(posedge aclk);
      chk("joined irq", 1'b1, irq);
      chk("joined priority", 3'h5, prio);
      wr(`TDP_OFF_LCTRL, 32'h0008);
      rchk("joined flags", `TDP_OFF_STAT, 32'h2);
      wr(`TDP_OFF_MASK, 32'h1);
      repeat (3) @(posedge aclk);
      chk("masked irq", 1'b0, irq);
      wr(`TDP_OFF_STAT, 32'h2);
      rchk("flags cleared", `TDP_OFF_STAT, 32'h0);
      $display("test joined done");
      // count words and time base outputs
      wr(`TDP_OFF_LCNT, 32'h1234);
      wr(`TDP_OFF_UCNT, 32'h5678);
      rchk("lower word", `TDP_OFF_LCNT, 32'h1234);
      rchk("upper word", `TDP_OFF_UCNT, 32'h5678);
      cap_sel <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("capture lower", 16'h1234, cap);
      chk("time base lower", 16'h1234, tb_lo);
      chk("time base upper", 16'h5678, tb_hi);
      cap_sel <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("capture upper", 16'h5678, cap);
      $display("test time base done");
      // idle behaviour, separate timers again
      wr(`TDP_OFF_LCTRL, 32'h0);
      wr(`TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_LPER, 32'hFFFF);
      idle <= 1'b1;
      wr(`TDP_OFF_LCTRL, 32'hA000);
      repeat (20) @(posedge aclk);
      rchk("halted in idle", `TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_LCTRL, 32'h8000);
      repeat (20) @(posedge aclk);
      wr(`TDP_OFF_LCTRL, 32'h0);
      // one tick per cycle from the run write landing to the stop write landing
      rchk("runs in idle", `TDP_OFF_LCNT, 32'h18);
      // joined pair in idle also obeys the upper halt bit
      wr(`TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_UCTRL, 32'h2000);
      wr(`TDP_OFF_LCTRL, 32'h8008);
      repeat (10) @(posedge aclk);
      rchk("joined halted in idle", `TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_UCTRL, 32'h0);
      repeat (10) @(posedge aclk);
      wr(`TDP_OFF_LCTRL, 32'h0);
      rchk("joined runs in idle", `TDP_OFF_LCNT, 32'hE);
      idle <= 1'b0;
      $display("test idle done");
      // external clock edges; gate bit ignored with external source
      wr(`TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_UCNT, 32'h0);
      // upper period still holds the joined test's word; keep it out of reach
      wr(`TDP_OFF_UPER, 32'hFFFF);
      wr(`TDP_OFF_LCTRL, 32'h8042);
      wr(`TDP_OFF_UCTRL, 32'h8002);
      pm.pulses(0, 5, 3);
      pm.pulses(1, 3, 2);
      repeat (8) @(posedge aclk);
      wr(`TDP_OFF_LCTRL, 32'h0);
      wr(`TDP_OFF_UCTRL, 32'h0);
      rchk("lower pin edges", `TDP_OFF_LCNT, 32'h5);
      rchk("upper pin edges", `TDP_OFF_UCNT, 32'h3);
      // gated accumulation on internal clock
      wr(`TDP_OFF_LCNT, 32'h0);
      wr(`TDP_OFF_STAT, 32'h3);
      wr(`TDP_OFF_LCTRL, 32'h8040);
      repeat (4) @(posedge aclk);
      pm.hold(0, 10);
      repeat (8) @(posedge aclk);
      wr(`TDP_OFF_LCTRL, 32'h0);
      rchk("gated count", `TDP_OFF_LCNT, 32'hA);
      rchk("gate fall flag", `TDP_OFF_STAT, 32'h1);
      chk("second converter idle", 32'h0, adc2_seen);
      $display("test external done");
      conclude();
   end
endmodule // tdp_timer_pair_tb
